//--- core/rtc_alarm_watchdog.sv
// Time-of-day alarm, BCD watchdog and command register behind the bytewide host bus.
//
// Function
// R1: Day alarm bits three to six read zero.
// R2: Bit seven of alarm registers is field mask.
// R3: No masks: alarm when minutes, hours, days match.
// R4: Day masked: alarm daily on hours and minutes.
// R5: Day and hour masked: alarm hourly on minutes.
// R6: All masked: alarm each seconds wrap.
// R7: Alarm registers keep time register layout.
// R8: Alarm register access clears alarm flag, output.
// R9: Watchdog period in two BCD registers.
// R10: Watchdog access reloads count, clears flag, output.
// R11: Countdown to zero drives watchdog output active.
// R12: Countdown repeats after each expiry.
// R13: Watchdog reads return period, not count.
// R14: Both watchdog registers zero disables watchdog.
// R15: Transfer enable zero freezes host clock copies.
// R16: Swap bit routes alarm and watchdog pins.
// R17: Polarity bit chooses source or sink drive.
// R18: Pulse mode asserts at least 3 ms.
// R19: Watchdog mask one keeps its output inactive.
// R20: Alarm mask one keeps its output inactive.
// R21: Watchdog flag set on expiry, cleared on access.
// R22: Alarm flag set on alarm, cleared on access.
// R23: Alarm contents are BCD like time counters.
// R24: Alarm compare happens while hundredths read 99.
// R25: Software programs only the four mask combinations.
// R26: Watchdog counts on hundredths ticks only.
// R27: First pin open drain, second pin polarity driven.
`timescale 1ns/1ps

`include "rtc_alarm_params.svh"

module rtc_alarm_watchdog
	import rtc_alarm_pkg::*;
#(
	parameter int PULSE_CYCLES = `IRQ_PULSE_MS * 1000 * `CLK_MHZ
)
(
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire host_bus_type bus_in,
	input wire logic hundredths_tick_in,
	input wire logic hundredths_99_in,
	input wire logic seconds_wrap_in,
	input wire time_fields_type next_time_in,
	input wire logic main_power_ok_in,
	output logic [7:0] data_out,
	output logic data_oe_out,
	output logic transfer_enable_out,
	output logic first_irq_output_out,
	output logic first_irq_output_oe_out,
	output logic second_irq_output_out,
	output logic second_irq_output_oe_out
);

	localparam logic [19:0] PULSE_LEN = 20'(PULSE_CYCLES);
	// A named copy of the reset byte lets single command bits be picked out without truncation.
	localparam logic [7:0] COMMAND_AT_RESET = `RESET_COMMAND;

	time_fields_type alarm;
	command_type command;
	logic [7:0] wd_low;
	logic [7:0] wd_high;
	logic [15:0] wd_count;
	logic access_prev;
	logic [1:0] flag;
	logic [1:0] pulse_active;
	logic [1:0] irq_event;
	logic [1:0] irq_clear;
	logic [1:0] irq_active;

	logic access;
	logic access_start;
	logic do_write;
	logic hit_alarm;
	logic hit_watchdog;
	logic hit_command;
	logic mapped;
	logic [7:0] read_value;
	logic alarm_match;
	logic wd_enabled;
	logic wd_expire;
	logic [15:0] wd_period;
	logic alarm_pin_active;
	logic watchdog_pin_active;
	logic first_active;
	logic second_active;
	logic second_sources;

	// A read or write is counted once, on the first cycle the strobes open it.
	assign access = !bus_in.chip_enable_n && (!bus_in.output_enable_n || !bus_in.write_enable_n);
	assign access_start = access && !access_prev;
	assign do_write = access_start && !bus_in.write_enable_n;

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			access_prev <= 1'b0;
		else
			access_prev <= access;
	end

	// Unmapped offsets decode to nothing, so an access there has no side effect at all.
	always_comb
	begin
		hit_alarm = 1'b0;
		hit_watchdog = 1'b0;
		hit_command = 1'b0;
		if (bus_in.address == `OFS_MINUTE_ALARM || bus_in.address == `OFS_HOUR_ALARM)
			hit_alarm = 1'b1;
		else if (bus_in.address == `OFS_DAY_ALARM)
			hit_alarm = 1'b1;
		else if (bus_in.address == `OFS_WD_LOW || bus_in.address == `OFS_WD_HIGH)
			hit_watchdog = 1'b1;
		else if (bus_in.address == `OFS_COMMAND)
			hit_command = 1'b1;
	end

	// Reads of unmapped offsets leave the data bus undriven.
	assign mapped = hit_alarm || hit_watchdog || hit_command;

	// Alarm values are stored as written, except day bits three to six, in the same BCD layout as the time registers. [R7] [R23]
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			alarm.minutes <= `RESET_ALARM;
			alarm.hours <= `RESET_ALARM;
			alarm.days <= `RESET_ALARM;
		end
		else if (do_write)
		begin
			if (bus_in.address == `OFS_MINUTE_ALARM)
				alarm.minutes <= bus_in.data;
			else if (bus_in.address == `OFS_HOUR_ALARM)
				alarm.hours <= bus_in.data;
			else if (bus_in.address == `OFS_DAY_ALARM)
				alarm.days <= bus_in.data & `DAY_ALARM_KEEP; // [R1]
		end
	end

	// The watchdog period; reads see these, never the live count. [R9] [R13]
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			wd_low <= `RESET_WD;
			wd_high <= `RESET_WD;
		end
		else if (do_write)
		begin
			if (bus_in.address == `OFS_WD_LOW)
				wd_low <= bus_in.data;
			else if (bus_in.address == `OFS_WD_HIGH)
				wd_high <= bus_in.data;
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			command.transfer_enable_bit <= COMMAND_AT_RESET[`BIT_TRANSFER_ENABLE];
			command.interrupt_swap_bit <= COMMAND_AT_RESET[`BIT_INTERRUPT_SWAP];
			command.second_irq_drive_polarity <= COMMAND_AT_RESET[`BIT_SECOND_POLARITY];
			command.irq_pulse_or_level_select <= COMMAND_AT_RESET[`BIT_PULSE_SELECT];
			command.watchdog_irq_mask <= COMMAND_AT_RESET[`BIT_WATCHDOG_MASK];
			command.alarm_irq_mask <= COMMAND_AT_RESET[`BIT_ALARM_MASK];
		end
		// The flag bits have no storage here, so writes to them are simply dropped.
		else if (do_write && hit_command)
		begin
			command.transfer_enable_bit <= bus_in.data[`BIT_TRANSFER_ENABLE];
			command.interrupt_swap_bit <= bus_in.data[`BIT_INTERRUPT_SWAP];
			command.second_irq_drive_polarity <= bus_in.data[`BIT_SECOND_POLARITY];
			command.irq_pulse_or_level_select <= bus_in.data[`BIT_PULSE_SELECT];
			command.watchdog_irq_mask <= bus_in.data[`BIT_WATCHDOG_MASK];
			command.alarm_irq_mask <= bus_in.data[`BIT_ALARM_MASK];
		end
	end

	// Masked fields drop out of the compare; the masks are cascaded by software. [R2] [R3] [R4] [R5] [R25]
	always_comb
	begin
		alarm_match = 1'b1;
		if (!alarm.minutes[`BIT_FIELD_MASK] && alarm.minutes[6:0] != next_time_in.minutes[6:0])
			alarm_match = 1'b0;
		if (!alarm.hours[`BIT_FIELD_MASK] && alarm.hours[6:0] != next_time_in.hours[6:0])
			alarm_match = 1'b0;
		if (!alarm.days[`BIT_FIELD_MASK] && alarm.days[2:0] != next_time_in.days[2:0])
			alarm_match = 1'b0;
	end

	// The compare is taken once per minute, on the tick that ends the 99 interval as seconds wrap.
	// With every mask set the match is always true, giving one alarm per minute. [R24] [R6]
	assign irq_event[SRC_ALARM] = hundredths_tick_in && hundredths_99_in && seconds_wrap_in && alarm_match;

	assign wd_period = {wd_high, wd_low};
	assign wd_enabled = wd_period != 16'h0000; // [R14]
	// Expiry is taken at a count of one on a tick, so a period of N fires on the N-th tick after a reload.
	assign wd_expire = wd_enabled && hundredths_tick_in && wd_count == 16'h0001; // [R11] [R26]
	assign irq_event[SRC_WATCHDOG] = wd_expire;

	// The borrow ripples through all four digits; a zero count never reaches it while enabled.
	function automatic logic [15:0] bcd_decrement(input logic [15:0] value);
		logic [15:0] result;
		logic borrow;
		result = value;
		borrow = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			if (borrow)
			begin
				if (value[i*4 +: 4] == 4'h0)
					result[i*4 +: 4] = 4'h9;
				else
				begin
					result[i*4 +: 4] = value[i*4 +: 4] - 4'h1;
					borrow = 1'b0;
				end
			end
		end
		return result;
	endfunction

	// Reload on any watchdog access or after expiry, so the watchdog recurs until software intervenes.
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			wd_count <= 16'h0000;
		else if (access_start && hit_watchdog)
		begin
			if (do_write && bus_in.address == `OFS_WD_LOW)
				wd_count <= {wd_high, bus_in.data}; // [R10]
			else if (do_write)
				wd_count <= {bus_in.data, wd_low}; // [R10]
			else
				wd_count <= wd_period; // [R10]
		end
		else if (wd_expire)
			wd_count <= wd_period; // [R12]
		else if (wd_enabled && hundredths_tick_in)
			wd_count <= bcd_decrement(wd_count); // [R11] [R26]
	end

	assign irq_clear[SRC_ALARM] = access_start && hit_alarm; // [R8]
	assign irq_clear[SRC_WATCHDOG] = access_start && hit_watchdog; // [R10]

	// Both sources share one flag and pulse timer design. A new event beats a clear in the same cycle.
	generate
		for (genvar s = 0; s < 2; s++)
		begin : source
			logic [19:0] pulse_count;

			always_ff @(posedge clk_in or negedge resetn_in)
			begin
				if (!resetn_in)
				begin
					flag[s] <= 1'b0;
					pulse_active[s] <= 1'b0;
					pulse_count <= 20'h0_0000;
				end
				else if (irq_event[s])
				begin
					flag[s] <= 1'b1; // [R21] [R22]
					pulse_active[s] <= 1'b1;
					pulse_count <= PULSE_LEN; // [R18]
				end
				else if (irq_clear[s])
				begin
					flag[s] <= 1'b0; // [R8] [R10] [R21] [R22]
					pulse_active[s] <= 1'b0;
					pulse_count <= 20'h0_0000;
				end
				else if (pulse_active[s])
				begin
					if (pulse_count <= 20'h0_0001)
					begin
						pulse_active[s] <= 1'b0;
						// In pulse mode the flag lives only as long as the pulse. [R21] [R22]
						if (command.irq_pulse_or_level_select)
							flag[s] <= 1'b0;
					end
					else
						pulse_count <= pulse_count - 20'h0_0001; // [R18]
				end
			end
		end
	endgenerate

	// The flag itself is the active state; in pulse mode it already ends with the pulse. [R18]
	assign irq_active[SRC_ALARM] = flag[SRC_ALARM] && !command.alarm_irq_mask; // [R20]
	assign irq_active[SRC_WATCHDOG] = flag[SRC_WATCHDOG] && !command.watchdog_irq_mask; // [R19]

	// A masked source still sets its flag; only its pin stays quiet.
	assign alarm_pin_active = irq_active[SRC_ALARM];
	assign watchdog_pin_active = irq_active[SRC_WATCHDOG];
	assign first_active = command.interrupt_swap_bit ? alarm_pin_active : watchdog_pin_active; // [R16]
	assign second_active = command.interrupt_swap_bit ? watchdog_pin_active : alarm_pin_active; // [R16]
	// Sourcing needs main power; on battery the second pin can only sink.
	assign second_sources = command.second_irq_drive_polarity && main_power_ok_in; // [R17]

	// Registering the pins costs a cycle of latency but keeps glitches off lines that leave the chip.
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			first_irq_output_out <= 1'b0;
			first_irq_output_oe_out <= 1'b0;
			second_irq_output_out <= 1'b0;
			second_irq_output_oe_out <= 1'b0;
		end
		else
		begin
			first_irq_output_out <= 1'b0; // [R27]
			first_irq_output_oe_out <= first_active; // [R27]
			second_irq_output_out <= second_sources; // [R17] [R27]
			second_irq_output_oe_out <= second_active; // [R27]
		end
	end

	// The live countdown has no read path; only the stored period is visible.
	always_comb
	begin
		read_value = 8'h00;
		if (bus_in.address == `OFS_MINUTE_ALARM)
			read_value = alarm.minutes;
		else if (bus_in.address == `OFS_HOUR_ALARM)
			read_value = alarm.hours;
		else if (bus_in.address == `OFS_DAY_ALARM)
			read_value = alarm.days; // [R1]
		else if (bus_in.address == `OFS_COMMAND)
		begin
			read_value[`BIT_TRANSFER_ENABLE] = command.transfer_enable_bit;
			read_value[`BIT_INTERRUPT_SWAP] = command.interrupt_swap_bit;
			read_value[`BIT_SECOND_POLARITY] = command.second_irq_drive_polarity;
			read_value[`BIT_PULSE_SELECT] = command.irq_pulse_or_level_select;
			read_value[`BIT_WATCHDOG_MASK] = command.watchdog_irq_mask;
			read_value[`BIT_ALARM_MASK] = command.alarm_irq_mask;
			read_value[`BIT_WATCHDOG_FLAG] = flag[SRC_WATCHDOG]; // [R21]
			read_value[`BIT_ALARM_FLAG] = flag[SRC_ALARM]; // [R22]
		end
		else if (bus_in.address == `OFS_WD_LOW)
			read_value = wd_low; // [R13]
		else if (bus_in.address == `OFS_WD_HIGH)
			read_value = wd_high; // [R13]
	end

	// Read data lags the strobes by one clock; the bus is far slower than the clock.
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			data_out <= 8'h00;
			data_oe_out <= 1'b0;
		end
		else
		begin
			data_out <= read_value;
			data_oe_out <= mapped && !bus_in.chip_enable_n && !bus_in.output_enable_n && bus_in.write_enable_n;
		end
	end

	// The counters outside copy to the host-visible registers only while this is high. [R15]
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			transfer_enable_out <= 1'b1;
		else
			transfer_enable_out <= command.transfer_enable_bit; // [R15]
	end

endmodule

//--- pkg/rtc_alarm_params.svh
// Offsets, field positions, reset values and timing figures of the alarm and watchdog block.
`ifndef RTC_ALARM_PARAMS_SVH
`define RTC_ALARM_PARAMS_SVH

`define OFS_MINUTE_ALARM 6'h03
`define OFS_HOUR_ALARM 6'h05
`define OFS_DAY_ALARM 6'h07
`define OFS_COMMAND 6'h0b
`define OFS_WD_LOW 6'h0c
`define OFS_WD_HIGH 6'h0d

`define BIT_TRANSFER_ENABLE 7
`define BIT_INTERRUPT_SWAP 6
`define BIT_SECOND_POLARITY 5
`define BIT_PULSE_SELECT 4
`define BIT_WATCHDOG_MASK 3
`define BIT_ALARM_MASK 2
`define BIT_WATCHDOG_FLAG 1
`define BIT_ALARM_FLAG 0
`define BIT_FIELD_MASK 7

`define DAY_ALARM_KEEP 8'h87
`define COMMAND_WRITABLE 8'hfc
`define RESET_ALARM 8'h00
`define RESET_COMMAND 8'h8c
`define RESET_WD 8'h00

`define IRQ_PULSE_MS 3
`define CLK_MHZ 250

`endif

//--- pkg/rtc_alarm_pkg.sv
// Types shared by the alarm and watchdog block.
package rtc_alarm_pkg;

	typedef struct packed {
		logic [7:0] minutes;
		logic [7:0] hours;
		logic [7:0] days;
	} time_fields_type;

	typedef struct packed {
		logic transfer_enable_bit;
		logic interrupt_swap_bit;
		logic second_irq_drive_polarity;
		logic irq_pulse_or_level_select;
		logic watchdog_irq_mask;
		logic alarm_irq_mask;
	} command_type;

	typedef struct packed {
		logic chip_enable_n;
		logic output_enable_n;
		logic write_enable_n;
		logic [5:0] address;
		logic [7:0] data;
	} host_bus_type;

	typedef enum int {
		SRC_ALARM = 0,
		SRC_WATCHDOG = 1
	} irq_source_type;

endpackage

//--- verif/rtc_alarm_watchdog_chk.sv
// Port checker for the alarm and watchdog block.
`timescale 1ns/1ps
module rtc_alarm_watchdog_chk
	import rtc_alarm_pkg::*;
#(
	parameter int PULSE_CYCLES = 20
)
(
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire host_bus_type bus_in,
	input wire logic main_power_ok_in,
	input wire logic [7:0] data_out,
	input wire logic transfer_enable_out,
	input wire logic first_irq_output_oe_out,
	input wire logic second_irq_output_out,
	input wire logic second_irq_output_oe_out
);
	logic prev, acc, start, rd, cw, wd_pin, al_pin;
	logic [7:0] cmd;
	logic [1:0] quiet;
	int run;
	assign acc = !bus_in.chip_enable_n && !(bus_in.output_enable_n && bus_in.write_enable_n);
	assign start = acc && !prev;
	assign rd = bus_in.write_enable_n;
	assign cw = start && !rd && bus_in.address == 6'h0b;
	assign wd_pin = cmd[6] ? second_irq_output_oe_out : first_irq_output_oe_out;
	assign al_pin = cmd[6] ? first_irq_output_oe_out : second_irq_output_oe_out;
	always_ff @(posedge clk_in or negedge resetn_in)
		if (!resetn_in)
			prev <= 1'b0;
		else
			prev <= acc;
	// A copy of the command byte lets the pin checks follow swap and masks.
	always_ff @(posedge clk_in or negedge resetn_in)
		if (!resetn_in)
			cmd <= 8'h8c;
		else if (cw)
			cmd <= bus_in.data;
	always_ff @(posedge clk_in or negedge resetn_in)
		if (!resetn_in)
			quiet <= 2'h0;
		else if (cw)
			quiet <= 2'h0;
		else if (quiet != 2'h3)
			quiet <= quiet + 2'h1;
	// Restarting on command writes avoids blaming a pulse that began in level mode.
	always_ff @(posedge clk_in or negedge resetn_in)
		if (!resetn_in)
			run <= 0;
		else
			run <= (second_irq_output_oe_out && !cw) ? run + 1 : 0;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);
	property p_day;
		start && rd && bus_in.address == 6'h07 |=> data_out[6:3] == 4'h0;
	endproperty
	a_day: assert property (p_day) else $error("day alarm bits not zero");
	property p_te;
		cw |-> ##2 transfer_enable_out == $past(bus_in.data[7], 2);
	endproperty
	a_te: assert property (p_te) else $error("transfer enable wrong");
	property p_wd_clr;
		start && bus_in.address inside {6'h0c, 6'h0d} |-> ##2 !wd_pin;
	endproperty
	a_wd_clr: assert property (p_wd_clr) else $error("watchdog pin not cleared");
	property p_al_clr;
		start && bus_in.address inside {6'h03, 6'h05, 6'h07} |-> ##2 !al_pin;
	endproperty
	a_al_clr: assert property (p_al_clr) else $error("alarm pin not cleared");
	property p_wd_mask;
		quiet[1] && cmd[3] |-> !wd_pin;
	endproperty
	a_wd_mask: assert property (p_wd_mask) else $error("masked watchdog pin active");
	property p_al_mask;
		quiet[1] && cmd[2] |-> !al_pin;
	endproperty
	a_al_mask: assert property (p_al_mask) else $error("masked alarm pin active");
	property p_pol;
		second_irq_output_oe_out && quiet[1] && $stable(main_power_ok_in)
			|-> second_irq_output_out == (cmd[5] && main_power_ok_in);
	endproperty
	a_pol: assert property (p_pol) else $error("second pin drive wrong");
	property p_pulse;
		cmd[4] && quiet[1] |-> run <= PULSE_CYCLES + 3;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse too long");
	c_wd: cover property (first_irq_output_oe_out && !cmd[6]);
	c_al: cover property (first_irq_output_oe_out && cmd[6]);
	c_pulse: cover property ($fell(second_irq_output_oe_out) && cmd[4]);
endmodule
bind rtc_alarm_watchdog rtc_alarm_watchdog_chk #(.PULSE_CYCLES(PULSE_CYCLES)) chk (.clk_in, .resetn_in, .bus_in,
	.main_power_ok_in, .data_out, .transfer_enable_out, .first_irq_output_oe_out, .second_irq_output_out,
	.second_irq_output_oe_out);

//--- verif/host_model.sv
// Host processor model driving the bytewide register bus.
`timescale 1ns/1ps
module host_model
	import rtc_alarm_pkg::*;
(
	input wire logic clk_in,
	output host_bus_type bus_out
);
	bit busy = 1'b0;
	initial bus_out = '{1'b1, 1'b1, 1'b1, 6'h00, 8'h00};
	// Between accesses address and data keep changing so stale values cannot pass.
	always @(posedge clk_in)
	begin
		#1;
		if (!busy)
			bus_out = '{1'b1, 1'b1, 1'b1, ~bus_out.address, ~bus_out.data};
	end
	task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
		busy = 1'b1;
		@(posedge clk_in);
		#1;
		bus_out = '{1'b0, w, !w, a, d};
		repeat (3) @(posedge clk_in);
		#1;
		bus_out = '{1'b1, 1'b1, 1'b1, a, d};
		@(posedge clk_in);
		busy = 1'b0;
	endtask
endmodule

//--- verif/tb_top.sv
// Self-checking bench for the alarm and watchdog block.
`timescale 1ns/1ps
module tb_top;
	import rtc_alarm_pkg::*;
	localparam int PC = 20;
	logic clk_in = 0, resetn_in = 0, hundredths_tick_in = 0, hundredths_99_in = 0, seconds_wrap_in = 0;
	logic main_power_ok_in = 1, data_oe_out, transfer_enable_out, oe_prev = 0;
	logic first_irq_output_out, first_irq_output_oe_out, second_irq_output_out, second_irq_output_oe_out;
	logic [7:0] data_out;
	time_fields_type next_time_in = '0;
	host_bus_type bus_in;
	logic [5:0] regs[6] = '{6'h03, 6'h05, 6'h07, 6'h0b, 6'h0c, 6'h0d};
	logic [7:0] exp_q[$];
	int failures = 0, num_checks = 0;
	always #2 clk_in = ~clk_in;
	host_model host (.clk_in(clk_in), .bus_out(bus_in));
	rtc_alarm_watchdog #(.PULSE_CYCLES(PC)) dut (.clk_in, .resetn_in, .bus_in, .hundredths_tick_in,
		.hundredths_99_in, .seconds_wrap_in, .next_time_in, .main_power_ok_in, .data_out, .data_oe_out,
		.transfer_enable_out, .first_irq_output_out, .first_irq_output_oe_out, .second_irq_output_out,
		.second_irq_output_oe_out);
	task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		host.acc(1'b1, a, d);
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.acc(1'b0, a, 8'h00);
	endtask
	task automatic tk(input logic h, input time_fields_type t);
		@(posedge clk_in);
		#1;
		{hundredths_tick_in, hundredths_99_in, seconds_wrap_in} = {1'b1, h, h};
		next_time_in = t;
		@(posedge clk_in);
		#1;
		{hundredths_tick_in, hundredths_99_in, seconds_wrap_in} = 3'h0;
		repeat (3) @(posedge clk_in);
	endtask
	task automatic pins(input logic a, input logic b);
		#1;
		check("first pin", {7'h00, first_irq_output_oe_out}, {7'h00, a});
		check("second pin", {7'h00, second_irq_output_oe_out}, {7'h00, b});
		check("first drive", {7'h00, first_irq_output_out}, 8'h00);
	endtask
	// Each rising read enable is one answer; the oldest note is its expectation.
	always @(posedge clk_in)
	begin
		if (data_oe_out === 1'b1 && !oe_prev)
			check("read data", data_out, exp_q.size() ? exp_q.pop_front() : 8'hxx);
		oe_prev = (data_oe_out === 1'b1);
	end
	initial
	begin
		#40000;
		failures++;
		conclude();
	end
	initial
	begin
		logic [7:0] v;
		time_fields_type t;
		void'($urandom(94));
		repeat (12) @(posedge clk_in);
		#1;
		resetn_in = 1;
		check("transfer enable", {7'h00, transfer_enable_out}, 8'h01);
		foreach (regs[i])
			rd(regs[i], i == 3 ? 8'h8c : 8'h00);
		host.acc(1'b0, 6'h08, 8'h00);
		foreach (regs[i])
		begin
			v = {4'($urandom_range(9)), 4'($urandom_range(9))};
			wr(regs[i], v);
			rd(regs[i], i == 2 ? v & 8'h87 : i == 3 ? v & 8'hfc : v);
		end
		wr(6'h0b, 8'h10);
		check("transfer enable", {7'h00, transfer_enable_out}, 8'h00);
		wr(6'h0d, 8'h00);
		wr(6'h0c, 8'h06);
		repeat (5) tk(1'b0, t);
		pins(0, 0);
		tk(1'b0, t);
		pins(1, 0);
		rd(6'h0b, 8'h12);
		repeat (4) tk(1'b0, t);
		pins(0, 0);
		rd(6'h0b, 8'h10);
		repeat (2) tk(1'b0, t);
		pins(1, 0);
		rd(6'h0c, 8'h06);
		pins(0, 0);
		wr(6'h0b, 8'h08);
		repeat (6) tk(1'b0, t);
		pins(0, 0);
		rd(6'h0b, 8'h0a);
		wr(6'h0c, 8'h00);
		wr(6'h0b, 8'h40);
		repeat (8) tk(1'b0, t);
		pins(0, 0);
		for (int c = 0; c < 4; c++)
		begin
			wr(6'h03, {c < 1, 7'h45});
			wr(6'h05, {c < 2, 7'h12});
			wr(6'h07, {c < 3, 7'h03});
			t = '{c < 1 ? 8'h17 : 8'h45, c < 2 ? 8'h08 : 8'h12, c < 3 ? 8'h05 : 8'h03};
			tk(1'b1, t);
			pins(1, 0);
			rd(6'h0b, 8'h41);
			rd(6'h03, {c < 1, 7'h45});
			pins(0, 0);
			if (c == 1)
				t.minutes = 8'h44;
			if (c == 2)
				t.hours = 8'h11;
			if (c == 3)
				t.days = 8'h04;
			tk(c > 0, t);
			pins(0, 0);
		end
		wr(6'h0b, 8'h30);
		tk(1'b1, '{8'h45, 8'h12, 8'h03});
		pins(0, 1);
		check("second drive", {7'h00, second_irq_output_out}, 8'h01);
		main_power_ok_in = 0;
		repeat (2) @(posedge clk_in);
		#1;
		check("second drive", {7'h00, second_irq_output_out}, 8'h00);
		main_power_ok_in = 1;
		repeat (PC) @(posedge clk_in);
		pins(0, 0);
		rd(6'h0b, 8'h30);
		wr(6'h0b, 8'h04);
		tk(1'b1, '{8'h45, 8'h12, 8'h03});
		pins(0, 0);
		rd(6'h0b, 8'h05);
		rd(6'h03, 8'h45);
		check("pending reads", 8'(exp_q.size()), 8'h00);
		conclude();
	end
endmodule
